/* shared/fps_pkg.sv */
package fps_pkg;

  // bus geometry
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 8;

  // register indices and byte addresses (byte address = 4 * index)
  localparam logic [5:0]  IDX_CONFIG  = 6'h03;
  localparam logic [5:0]  IDX_PROT    = 6'h04;
  localparam logic [5:0]  IDX_STATUS  = 6'h05;
  localparam logic [7:0]  ADDR_CONFIG = {IDX_CONFIG, 2'b00};
  localparam logic [7:0]  ADDR_PROT   = {IDX_PROT, 2'b00};
  localparam logic [7:0]  ADDR_STATUS = {IDX_STATUS, 2'b00};

  // command_status bit positions
  localparam int          ST_BUF_EMPTY = 7;
  localparam int          ST_COMPLETE  = 6;
  localparam int          ST_PROT_VIOL = 5;
  localparam int          ST_ACC_ERR   = 4;
  localparam int          ST_BLANK     = 2;
  localparam int          ST_FAIL      = 1;
  localparam int          ST_DONE      = 0;

  // protection_register bit positions
  localparam int          PR_POLARITY  = 7;
  localparam int          PR_SPARE     = 6;
  localparam int          PR_HI_DIS    = 5;
  localparam int          PR_HI_SIZE   = 3;
  localparam int          PR_LO_DIS    = 2;
  localparam int          PR_LO_SIZE   = 0;

  // flash_config_register bit positions
  localparam int          CF_BE_IE     = 7;
  localparam int          CF_CC_IE     = 6;
  localparam logic [7:0]  CONFIG_MASK  = 8'hc0;

  // reset values
  localparam logic [7:0]  PROT_RST     = 8'hff;
  localparam logic [7:0]  CONFIG_RST   = 8'h00;
  localparam logic        BUF_EMPTY_RST = 1'b1;
  localparam logic        COMPLETE_RST  = 1'b1;

  // protection windows
  localparam logic [15:0] HI_BASE [4] = '{16'hf800, 16'hf000, 16'he000, 16'hc000};
  localparam logic [15:0] LO_BASE     = 16'h4000;
  localparam logic [15:0] LO_TOP  [4] = '{16'h43ff, 16'h47ff, 16'h4fff, 16'h5fff};

  // scenario index = {polarity, low disable, high disable}; bit n = target n allowed
  localparam logic [7:0]  TRANS_ALLOW [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08,
                                              8'h18, 8'h3c, 8'h5a, 8'hff};

  // command engine to this block
  typedef struct packed {
    logic        word_wr;
    logic [15:0] addr;
    logic        pgm_erase;
    logic        seq_violation;
    logic        cpu_stop;
    logic        busy;
    logic        buf_taken;
    logic        ev_blank;
    logic        ev_not_blank;
  } fps_engine_in_type;

  // this block to command engine
  typedef struct packed {
    logic        launch;
    logic        seq_abort;
  } fps_engine_out_type;

endpackage : fps_pkg

/* core/fps_top.sv */
`timescale 1ns/1ps

// Summary of operation
// - polarity 1: disable bit 0 protects its range; both disabled means no protection.
// - polarity 0 with both disable bits 1 protects the whole array.
// - polarity 0: a range with disable 0 is the only unprotected region.
// - high window ends at 0xffff, 2-16 KB; low window starts 0x4000, 1-8 KB.
// - protection loads from the array after reset; software may change it later.
// - disallowed scenario writes are silently dropped; readback shows active scenario.
// - only the listed scenario transitions are accepted.
// - normal modes: empty, violation, error writable; complete, blank read-only; rest zero.
// - special modes: fail writable, done read-only; fail must be clear to start.
// - buffer-empty at bit 7; write 1 launches and clears, write 0 no change.
// - write 0 to buffer-empty mid-sequence aborts and sets access error.
// - interrupt requests from buffer-empty and complete flags with their enables.
// - complete clears while buffer-empty clear, sets only when all commands done.
// - violation at bit 5 sets on protected program or erase, write-1 clears, blocks launch.
// - access error at bit 4 on sequence fault, bad command, stop while busy.
// - blank at bit 2 sets on erased verify, clears on new valid launch.
// - special modes: fail at bit 1 sets on failed verify, write-1 clears, blocks launch.
// - special modes: done at bit 0 is 0 while an operation runs, else 1.
// - size fields are writable only while their disable bit is set.
// - protection layout: polarity 7, high disable 5, size 4-3, low disable 2, size 1-0.
module fps_top (
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // apb slave
  input  wire logic                        i_psel,
  input  wire logic                        i_penable,
  input  wire logic                        i_pwrite,
  input  wire logic [fps_pkg::ADDR_W-1:0]  i_paddr,
  input  wire logic [fps_pkg::DATA_W-1:0]  i_pwdata,
  output logic      [fps_pkg::DATA_W-1:0]  o_prdata,
  output logic                             o_pready,
  output logic                             o_pslverr,
  // chip mode and nonvolatile protection image
  input  wire logic                        i_special_mode,
  input  wire logic [fps_pkg::REG_W-1:0]   i_nv_prot,
  // command engine
  input  wire fps_pkg::fps_engine_in_type  i_engine,
  output fps_pkg::fps_engine_out_type      o_engine,
  // interrupt requests
  output logic                             o_buf_empty_irq,
  output logic                             o_complete_irq
);

  // bus state
  logic [fps_pkg::DATA_W-1:0] prdata_ff;
  logic                       pready_ff;
  logic                       pslverr_ff;

  // registers and flags
  logic [7:0]  config_ff;
  logic [7:0]  prot_ff;
  logic        loaded_ff;
  logic        buf_empty_ff;
  logic        complete_ff;
  logic        prot_viol_ff;
  logic        acc_err_ff;
  logic        blank_ff;
  logic        fail_ff;
  logic        done_ff;
  logic        seq_ff;
  logic [15:0] seq_addr_ff;
  logic        launch_ff;
  logic        abort_ff;
  logic        be_irq_ff;
  logic        cc_irq_ff;

  // bus decode
  wire         setup     = i_psel & ~i_penable;
  wire         wr_acc    = i_psel & i_penable & i_pwrite & pready_ff;
  wire         hit_cfg   = (i_paddr == fps_pkg::ADDR_CONFIG);
  wire         hit_prot  = (i_paddr == fps_pkg::ADDR_PROT);
  wire         hit_st    = (i_paddr == fps_pkg::ADDR_STATUS);
  wire         mapped    = hit_cfg | hit_prot | hit_st;
  wire  [7:0]  wd        = i_pwdata[7:0];
  wire         wr_cfg    = wr_acc & hit_cfg;
  wire         wr_prot   = wr_acc & hit_prot;
  wire         wr_st     = wr_acc & hit_st;

  // protection fields
  wire         pol       = prot_ff[fps_pkg::PR_POLARITY];
  wire         hi_dis    = prot_ff[fps_pkg::PR_HI_DIS];
  wire         lo_dis    = prot_ff[fps_pkg::PR_LO_DIS];
  wire  [1:0]  hi_size   = prot_ff[fps_pkg::PR_HI_SIZE +: 2];
  wire  [1:0]  lo_size   = prot_ff[fps_pkg::PR_LO_SIZE +: 2];

  // address window decode
  wire         in_hi     = (seq_addr_ff >= fps_pkg::HI_BASE[hi_size]);
  wire         in_lo     = (seq_addr_ff >= fps_pkg::LO_BASE) &
                           (seq_addr_ff <= fps_pkg::LO_TOP[lo_size]);
  wire         win_sel   = (~hi_dis & in_hi) | (~lo_dis & in_lo);
  // polarity 1 protects selected windows, polarity 0 protects everything else
  wire         addr_prot = pol ? win_sel : ~win_sel;

  // scenario transition check
  wire  [2:0]  cur_idx   = {pol, lo_dis, hi_dis};
  wire  [2:0]  new_idx   = {wd[fps_pkg::PR_POLARITY], wd[fps_pkg::PR_LO_DIS],
                            wd[fps_pkg::PR_HI_DIS]};
  wire  [7:0]  allow_row = fps_pkg::TRANS_ALLOW[cur_idx];
  wire         allowed   = allow_row[new_idx];
  wire  [1:0]  nxt_hsize = hi_dis ? wd[fps_pkg::PR_HI_SIZE +: 2] : hi_size;
  wire  [1:0]  nxt_lsize = lo_dis ? wd[fps_pkg::PR_LO_SIZE +: 2] : lo_size;
  wire  [7:0]  prot_wr   = {wd[fps_pkg::PR_POLARITY], prot_ff[fps_pkg::PR_SPARE],
                            wd[fps_pkg::PR_HI_DIS], nxt_hsize,
                            wd[fps_pkg::PR_LO_DIS], nxt_lsize};
  wire  [7:0]  nxt_prot  = ~loaded_ff          ? i_nv_prot :
                           (wr_prot & allowed) ? prot_wr   :
                                                 prot_ff;

  // command launch decisions
  wire         launch_req  = wr_st & wd[fps_pkg::ST_BUF_EMPTY] & buf_empty_ff;
  // any error flag stalls launch; the write-1 is then simply ignored
  wire         err_block   = prot_viol_ff | acc_err_ff | fail_ff;
  wire         launch_try  = launch_req & ~err_block;
  wire         hit_guard   = i_engine.pgm_erase & addr_prot;
  wire         launch_bad  = launch_try & ~seq_ff;
  wire         launch_viol = launch_try & seq_ff & hit_guard;
  wire         launch_ok   = launch_try & seq_ff & ~hit_guard;
  wire         abort_zero  = wr_st & ~wd[fps_pkg::ST_BUF_EMPTY] & seq_ff & buf_empty_ff;
  wire         seq_clr     = launch_ok | launch_viol | abort_zero | i_engine.seq_violation;
  wire         nxt_seq     = i_engine.word_wr | (seq_ff & ~seq_clr);

  // flag next values, set beats clear
  wire         nxt_buf_empty = i_engine.buf_taken | (buf_empty_ff & ~launch_ok);
  // engine keeps busy high across a pending command so complete never blips
  wire         nxt_complete  = nxt_buf_empty & ~i_engine.busy;
  wire         viol_set      = launch_viol;
  wire         viol_clr      = wr_st & wd[fps_pkg::ST_PROT_VIOL];
  wire         nxt_viol      = viol_set | (prot_viol_ff & ~viol_clr);
  wire         err_set       = launch_bad | abort_zero | i_engine.seq_violation |
                               (i_engine.cpu_stop & ~complete_ff);
  wire         err_clr       = wr_st & wd[fps_pkg::ST_ACC_ERR];
  wire         nxt_err       = err_set | (acc_err_ff & ~err_clr);
  wire         nxt_blank     = i_engine.ev_blank | (blank_ff & ~launch_ok);
  wire         fail_set      = i_special_mode & i_engine.ev_not_blank;
  wire         fail_clr      = i_special_mode & wr_st & wd[fps_pkg::ST_FAIL];
  wire         nxt_fail      = fail_set | (fail_ff & ~fail_clr);
  wire         nxt_done      = ~i_engine.busy;

  // register readback
  wire  [7:0]  status_view = {buf_empty_ff, complete_ff, prot_viol_ff, acc_err_ff,
                              1'b0, blank_ff,
                              i_special_mode & fail_ff,
                              i_special_mode & done_ff};
  wire  [7:0]  rd_byte     = hit_cfg  ? config_ff   :
                             hit_prot ? prot_ff     :
                             hit_st   ? status_view :
                                        8'h00;
  wire  [7:0]  nxt_config  = wr_cfg ? (wd & fps_pkg::CONFIG_MASK) : config_ff;

  // apb answer: read data sampled in setup, ready in the access cycle
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= setup;
      pslverr_ff <= setup & ~mapped;
      if (setup) begin
        prdata_ff <= {24'h00_0000, rd_byte};
      end
    end
  end

  // protection register, loaded from the array image once after reset
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      prot_ff   <= fps_pkg::PROT_RST;
      loaded_ff <= 1'b0;
      config_ff <= fps_pkg::CONFIG_RST;
    end else begin
      prot_ff   <= nxt_prot;
      loaded_ff <= 1'b1;
      config_ff <= nxt_config;
    end
  end

  // command sequence tracking
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seq_ff      <= 1'b0;
      seq_addr_ff <= 16'h0000;
    end else begin
      seq_ff <= nxt_seq;
      if (i_engine.word_wr) begin
        seq_addr_ff <= i_engine.addr;
      end
    end
  end

  // status flags
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      buf_empty_ff <= fps_pkg::BUF_EMPTY_RST;
      complete_ff  <= fps_pkg::COMPLETE_RST;
      prot_viol_ff <= 1'b0;
      acc_err_ff   <= 1'b0;
      blank_ff     <= 1'b0;
      fail_ff      <= 1'b0;
      done_ff      <= 1'b1;
    end else begin
      buf_empty_ff <= nxt_buf_empty;
      complete_ff  <= nxt_complete;
      prot_viol_ff <= nxt_viol;
      acc_err_ff   <= nxt_err;
      blank_ff     <= nxt_blank;
      fail_ff      <= nxt_fail;
      done_ff      <= nxt_done;
    end
  end

  // engine strobes and interrupt requests
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      launch_ff <= 1'b0;
      abort_ff  <= 1'b0;
      be_irq_ff <= 1'b0;
      cc_irq_ff <= 1'b0;
    end else begin
      launch_ff <= launch_ok;
      abort_ff  <= abort_zero | launch_viol;
      be_irq_ff <= nxt_buf_empty & nxt_config[fps_pkg::CF_BE_IE];
      cc_irq_ff <= nxt_complete & nxt_config[fps_pkg::CF_CC_IE];
    end
  end

  assign o_prdata           = prdata_ff;
  assign o_pready           = pready_ff;
  assign o_pslverr          = pslverr_ff;
  assign o_engine.launch    = launch_ff;
  assign o_engine.seq_abort = abort_ff;
  assign o_buf_empty_irq    = be_irq_ff;
  assign o_complete_irq     = cc_irq_ff;

endmodule : fps_top

/* verif/fps_checker.sv */
`timescale 1ns/1ps
module fps_checker (
  // clock, reset and apb
  input wire logic                        i_clk, i_rst, i_psel, i_penable, i_pwrite,
  input wire logic [fps_pkg::ADDR_W-1:0]  i_paddr,
  input wire logic [fps_pkg::DATA_W-1:0]  i_pwdata, o_prdata,
  input wire logic                        o_pready, o_pslverr,
  // mode and engine
  input wire logic                        i_special_mode,
  input wire fps_pkg::fps_engine_out_type o_engine
);
  logic st_wr;
  assign st_wr = i_psel & i_penable & i_pwrite & o_pready & (i_paddr == fps_pkg::ADDR_STATUS);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no pready after setup");
  property p_one; o_pready |=> !o_pready; endproperty
  a_one: assert property (p_one) else $error("pready too long");
  property p_err; o_pslverr && !i_pwrite |-> o_pready && o_prdata == '0; endproperty
  a_err: assert property (p_err) else $error("bad unmapped read");
  property p_lch; o_engine.launch |-> $past(st_wr && i_pwdata[7]); endproperty
  a_lch: assert property (p_lch) else $error("launch without write");
  property p_lpl; o_engine.launch |=> !o_engine.launch; endproperty
  a_lpl: assert property (p_lpl) else $error("launch too long");
  property p_abt; o_engine.seq_abort |-> $past(st_wr); endproperty
  a_abt: assert property (p_abt) else $error("abort without write");
  property p_xcl; o_engine.seq_abort |-> !o_engine.launch; endproperty
  a_xcl: assert property (p_xcl) else $error("protected launch ran");
  property p_nrm; o_pready && !i_pwrite && !i_special_mode && i_paddr == fps_pkg::ADDR_STATUS
    |-> o_prdata[3] == 1'b0 && o_prdata[1:0] == 2'b00; endproperty
  a_nrm: assert property (p_nrm) else $error("hidden status bits seen");
  c_lch: cover property (o_engine.launch);
  c_abt: cover property (o_engine.seq_abort);
  c_err: cover property (o_pslverr);
endmodule : fps_checker
bind fps_top fps_checker u_fps_checker (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_special_mode(i_special_mode), .o_engine(o_engine));

/* verif/fps_engine_model.sv */
`timescale 1ns/1ps
module fps_engine_model (
  // clock, reset and launch
  input wire logic       i_clk, i_rst, i_launch, i_verify_ok,
  input wire logic [3:0] i_dur,
  // engine status
  output logic           o_busy, o_taken, o_blank, o_not_blank
);
  logic [3:0] cnt_ff;
  logic       last;
  // busy stands with the buffer grab, so complete cannot set early
  assign last = o_busy & (cnt_ff == 4'h1);
  always_ff @(posedge i_clk) begin
    o_taken <= i_launch & ~i_rst;
    o_blank <= last & i_verify_ok & ~i_rst;
    o_not_blank <= last & ~i_verify_ok & ~i_rst;
    if (i_rst || i_launch) cnt_ff <= i_rst ? 4'h0 : i_dur;
    else if (cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
    o_busy <= ~i_rst & (i_launch | (cnt_ff > 4'h1));
  end
endmodule : fps_engine_model

/* verif/flash_protect_and_status_test.sv */
`timescale 1ns/1ps
module flash_protect_and_status_test;
  logic clk, rst, psel, pen, pwr, ww, sv, sp, vok, pready, pslverr, e, bei, cci, bsy, tkn, bl, nbl;
  logic        pe, cs, q;
  logic [7:0]  paddr, pw, nv, p, x;
  logic [15:0] ad, a;
  logic [31:0] prdata, r;
  int          mismatches, checks, nl, na, l0, a0, k;
  fps_pkg::fps_engine_in_type  eng;
  fps_pkg::fps_engine_out_type eo;
  localparam logic [7:0] ST = fps_pkg::ADDR_STATUS, PR = fps_pkg::ADDR_PROT, CF = fps_pkg::ADDR_CONFIG;
  localparam logic [7:0] ALLOW [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
  assign eng = '{word_wr: ww, addr: ad, pgm_erase: pe, seq_violation: sv, cpu_stop: cs,
                 busy: bsy, buf_taken: tkn, ev_blank: bl, ev_not_blank: nbl};
  fps_top u_fps_top (.i_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata({24'h0, pw}), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_special_mode(sp), .i_nv_prot(nv), .i_engine(eng), .o_engine(eo),
    .o_buf_empty_irq(bei), .o_complete_irq(cci));
  fps_engine_model u_fps_engine_model (.i_clk(clk), .i_rst(rst), .i_launch(eo.launch),
    .i_verify_ok(vok), .i_dur(4'hc), .o_busy(bsy), .o_taken(tkn), .o_blank(bl), .o_not_blank(nbl));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    nl += int'(eo.launch === 1'b1);
    na += int'(eo.seq_abort === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] adr, input logic [7:0] d);
    int n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= adr;
    pw <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) begin
      mismatches++;
      $display("mismatch at %0t: no pready", $time);
    end
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic rd(input logic [7:0] adr, input logic [7:0] xp, input string m);
    apb(1'b0, adr, 8'h00);
    chk(r, {24'h0, xp}, m);
  endtask : rd
  task automatic start(input logic [7:0] img);
    nv <= img;
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : start
  task automatic word(input logic [15:0] wa);
    ad <= wa;
    ww <= 1'b1;
    @(posedge clk);
    ww <= 1'b0;
  endtask : word
  task automatic settle;
    int n = 0;
    repeat (3) @(posedge clk);
    while (bsy !== 1'b0 && ++n < 40) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask : settle
  function automatic logic prot(logic [7:0] pr, logic [15:0] fa);
    logic hi, lo;
    hi = !pr[5] && {1'b0, fa} >= 17'h10000 - (17'h00800 << pr[4:3]);
    lo = !pr[2] && fa >= 16'h4000 && fa < 16'h4000 + (16'h0400 << pr[1:0]);
    return pr[7] ? hi | lo : (pr[5] & pr[2]) | !(hi | lo);
  endfunction : prot
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
  initial begin
    {rst, vok, psel, pen, pwr, ww, sv, sp, pe, cs} = 10'h302;
    {paddr, pw, nv, ad} = 40'h0;
    void'($urandom(32'h73fcdee2));
    start(8'hff);
    rd(ST, 8'hc0, "status reset");
    rd(PR, 8'hff, "prot load");
    rd(8'h00, 8'h00, "unmapped");
    chk(e, 1'b1, "slverr");
    apb(1'b1, CF, 8'hff);
    rd(CF, 8'hc0, "config");
    chk({bei, cci}, 2'b11, "irq on");
    word(16'h8000);
    apb(1'b1, ST, 8'h00);
    rd(ST, 8'hd0, "abort");
    apb(1'b1, ST, 8'h80);
    rd(ST, 8'hd0, "blocked");
    apb(1'b1, ST, 8'h10);
    word(16'h8000);
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    rd(ST, 8'hd0, "seq fault");
    apb(1'b1, ST, 8'h10);
    word(16'h8000);
    apb(1'b1, ST, 8'h80);
    settle();
    rd(ST, 8'hc4, "blank");
    chk(nl, 1, "launches");
    $display("test flags done");
    sp <= 1'b1;
    vok <= 1'b0;
    word(16'h8000);
    apb(1'b1, ST, 8'h80);
    repeat (3) @(posedge clk);
    rd(ST, 8'h80, "busy");
    // stop while the operation runs must flag an access error
    cs <= 1'b1;
    @(posedge clk);
    cs <= 1'b0;
    settle();
    rd(ST, 8'hd3, "fail");
    sp <= 1'b0;
    rd(ST, 8'hd0, "hidden");
    sp <= 1'b1;
    apb(1'b1, ST, 8'h12);
    // stop with nothing running leaves the error clear
    cs <= 1'b1;
    @(posedge clk);
    cs <= 1'b0;
    rd(ST, 8'hc1, "fail clear");
    apb(1'b1, CF, 8'h40);
    @(posedge clk);
    chk({bei, cci}, 2'b01, "irq mask");
    $display("test special done");
    for (k = 0; k < 64; k++) begin
      start({k[5], 1'b1, k[3], 2'b11, k[4], 2'b11});
      apb(1'b1, PR, {k[2], 1'b0, k[0], 2'b00, k[1], 2'b00});
      x = {k[2], 1'b1, k[0], {2{!k[3]}}, k[1], {2{!k[4]}}};
      rd(PR, ALLOW[k[5:3]][k[2:0]] ? x : nv, "transition");
    end
    $display("test transitions done");
    for (k = 0; k < 40; k++) begin
      p = 8'($urandom);
      q = 1'($urandom_range(1));
      pe <= q;
      a = $urandom_range(1) ? 16'h0000 - (16'h0800 << p[4:3]) : 16'h4000 + (16'h0400 << p[1:0]);
      a -= 16'($urandom_range(1));
      start(p);
      // only program or erase is policed against the windows
      q = q & prot(p, a);
      {l0, a0} = {nl, na};
      word(a);
      apb(1'b1, ST, 8'h80);
      repeat (2) @(posedge clk);
      chk(na - a0, q, "abort count");
      chk(nl - l0, !q, "launch count");
      apb(1'b0, ST, 8'h00);
      chk(r[5], q, "violation flag");
    end
    $display("test violation done");
    conclude();
  end
endmodule : flash_protect_and_status_test
